// ### eifkm_pkg.sv
// Constants, register map and sense decoding for the external request flag and key mask block
// Overview of operation
// - Sixteen request flags reset to zero and set on their selected sense condition.
// - Software clears a flag only with a zero write after it read the flag as one.
// - Level-low mode: exception handling clears the flag while the selected pin is high.
// - Edge modes: exception handling for that line clears its flag unless a new edge sets it in the same cycle.
// - Flag registers accept only written zeros; a written one never sets a flag.
// - Upper key mask bits gate key inputs 15..8; zero enables; reset to ones.
// - Lower key mask bits gate key inputs 7..0; all reset to one except bit six.
// - Wake event mask bits gate wake inputs 15..8; zero enables; reset to ones.
// - Compatible mode: key mask bit six also gates request line six; resets to zero.
// - Extended mode: key mask bit six becomes one and stops gating line six.
// - Compatible mode: request-seven pin ignored while any upper key mask bit is zero.
// - Compatible mode: the alternate line-six pin never produces a request.
// - Extended mode: the alternate line-six pin sources request line six.
// - Sense field codes: 00 low, 01 falling, 10 rising, 11 both edges.
// - A pending request reaches request_pending only when its enable bit is one; irq does not use the enable bits.
package eifkm_pkg;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_FLAGS_HI  = 8'h00;
    localparam logic [7:0] OFS_FLAGS_LO  = 8'h04;
    localparam logic [7:0] OFS_KMASK_HI  = 8'h08;
    localparam logic [7:0] OFS_KMASK_LO  = 8'h0C;
    localparam logic [7:0] OFS_WMASK     = 8'h10;
    localparam logic [7:0] OFS_SENSE_HI  = 8'h14;
    localparam logic [7:0] OFS_SENSE_LO  = 8'h18;
    localparam logic [7:0] OFS_ENABLE    = 8'h1C;
    localparam logic [7:0] OFS_PIN_SEL   = 8'h20;
    localparam logic [7:0] OFS_SYSCTL    = 8'h24;
    localparam logic [7:0] OFS_IRQ_STS   = 8'h28;
    localparam logic [7:0] OFS_IRQ_MSK   = 8'h2C;

    // Field positions
    localparam int EVS_BIT      = 0;
    localparam int KMASK_SIX    = 6;
    localparam int LINE_SIX     = 6;
    localparam int LINE_SEVEN   = 7;

    // Reset values
    localparam logic [7:0]  RST_KMASK_HI = 8'hFF;
    localparam logic [7:0]  RST_KMASK_LO = 8'hBF;
    localparam logic [7:0]  RST_WMASK    = 8'hFF;
    localparam logic [15:0] RST_FLAGS    = 16'h0000;
    localparam logic [15:0] RST_SENSE    = 16'h0000;
    localparam logic [15:0] RST_ENABLE   = 16'h0000;
    localparam logic [15:0] RST_PIN_SEL  = 16'h0000;
    localparam logic [15:0] RST_PIN_IDLE = 16'hFFFF;
    localparam logic [15:0] PIN_SEL_WMSK = 16'hFF80;

    // Sense field codes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    // Request detect on an active-low pin, previous and present sample
    function automatic logic eifkm_detect(input logic [1:0] mode, input logic prev_n,
                                          input logic cur_n);
        case (mode)
            SENSE_LOW:  eifkm_detect = ~cur_n;
            SENSE_FALL: eifkm_detect = prev_n & ~cur_n;
            SENSE_RISE: eifkm_detect = ~prev_n & cur_n;
            default:    eifkm_detect = prev_n ^ cur_n;
        endcase
    endfunction : eifkm_detect

endpackage : eifkm_pkg

// ### eifkm_core.sv
// External request flags, key and wake masks, with Avalon-MM register slave
`timescale 1ns/100ps
module eifkm_core (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Request pins, active low
    input  wire logic [15:0] primary_request_pin_n,
    input  wire logic [15:6] alternate_request_pin_n,
    input  wire logic [15:0] key_sense_input_n,
    input  wire logic [15:8] wake_event_input_n,
    // Exception handling acknowledge
    input  wire logic        exc_ack,
    input  wire logic [3:0]  exc_line,
    // Processor side
    output logic      [15:0] request_pending,
    output logic      [15:0] key_sense_hit,
    output logic      [15:8] wake_event_hit,
    output logic             irq
);

    // Register state
    logic [15:0] flag_q;
    logic [15:0] rd_seen_q;
    logic [7:0]  kmask_hi_q;
    logic [7:0]  kmask_lo_q;
    logic [7:0]  wmask_q;
    logic [15:0] sense_hi_q;
    logic [15:0] sense_lo_q;
    logic [15:0] enable_q;
    logic [15:0] pin_sel_q;
    logic        evs_q;
    logic [15:0] sts_q;
    logic [15:0] msk_q;
    logic [15:0] prev_n_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [15:0] key_hit_q;
    logic [7:0]  wake_hit_q;

    // Bus decode; one wait state lets read data come from a flop
    wire         req     = avs_read | avs_write;
    wire         wr_acc  = avs_write & ack_q;
    wire         rd_acc  = avs_read & ack_q;
    wire         sel_fhi = avs_address == eifkm_pkg::OFS_FLAGS_HI;
    wire         sel_flo = avs_address == eifkm_pkg::OFS_FLAGS_LO;
    wire         sel_kmh = avs_address == eifkm_pkg::OFS_KMASK_HI;
    wire         sel_kml = avs_address == eifkm_pkg::OFS_KMASK_LO;
    wire         sel_wm  = avs_address == eifkm_pkg::OFS_WMASK;
    wire         sel_sh  = avs_address == eifkm_pkg::OFS_SENSE_HI;
    wire         sel_sl  = avs_address == eifkm_pkg::OFS_SENSE_LO;
    wire         sel_en  = avs_address == eifkm_pkg::OFS_ENABLE;
    wire         sel_ps  = avs_address == eifkm_pkg::OFS_PIN_SEL;
    wire         sel_sc  = avs_address == eifkm_pkg::OFS_SYSCTL;
    wire         sel_is  = avs_address == eifkm_pkg::OFS_IRQ_STS;
    wire         sel_im  = avs_address == eifkm_pkg::OFS_IRQ_MSK;
    wire [7:0]   wbyte   = avs_writedata[7:0];
    wire [15:0]  whalf   = avs_writedata[15:0];

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdata_q;

    // Read mux; unmapped offsets read zero
    wire [31:0] rd_mux =
        sel_fhi ? {24'h000000, flag_q[15:8]} :
        sel_flo ? {24'h000000, flag_q[7:0]} :
        sel_kmh ? {24'h000000, kmask_hi_q} :
        sel_kml ? {24'h000000, kmask_lo_q} :
        sel_wm  ? {24'h000000, wmask_q} :
        sel_sh  ? {16'h0000, sense_hi_q} :
        sel_sl  ? {16'h0000, sense_lo_q} :
        sel_en  ? {16'h0000, enable_q} :
        sel_ps  ? {16'h0000, pin_sel_q} :
        sel_sc  ? {31'h0, evs_q} :
        sel_is  ? {16'h0000, sts_q} :
        sel_im  ? {16'h0000, msk_q} : 32'h00000000;

    // Line sources, active low; key groups fold onto lines six and seven in compatible mode only
    wire [15:0] sel_pin_n = (pin_sel_q & {alternate_request_pin_n, 6'h3F})
                          | (~pin_sel_q & primary_request_pin_n);
    wire        key_lo_n  = &(key_sense_input_n[7:0] | kmask_lo_q);
    wire        key_hi_n  = &(key_sense_input_n[15:8] | kmask_hi_q);
    wire        kh_all    = &kmask_hi_q;
    // Compatible mode: primary seven dropped once any upper key is enabled
    wire        src7_n    = evs_q ? sel_pin_n[eifkm_pkg::LINE_SEVEN] :
                            (kh_all ? primary_request_pin_n[eifkm_pkg::LINE_SEVEN] : key_hi_n);
    // Alternate six only counts in extended mode
    wire        src6_n    = evs_q ? alternate_request_pin_n[eifkm_pkg::LINE_SIX] :
                            (primary_request_pin_n[eifkm_pkg::LINE_SIX] & key_lo_n);
    wire [15:0] src_n     = {sel_pin_n[15:8], src7_n, src6_n, primary_request_pin_n[5:0]};
    wire [31:0] sense_all = {sense_hi_q, sense_lo_q};

    // Software clears: zero written to a flag already read as one
    wire [15:0] wr_zero  = {(wr_acc & sel_fhi) ? ~wbyte : 8'h00,
                            (wr_acc & sel_flo) ? ~wbyte : 8'h00};
    wire [15:0] rd_one   = {(rd_acc & sel_fhi) ? rdata_q[7:0] : 8'h00,
                            (rd_acc & sel_flo) ? rdata_q[7:0] : 8'h00};
    wire [15:0] sw_clr   = wr_zero & rd_seen_q;

    // Per-line detect and exception-handling clear
    logic [15:0] set_ev;
    logic [15:0] exc_clr;
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            set_ev[n]  = eifkm_pkg::eifkm_detect(sense_all[2*n +: 2], prev_n_q[n], src_n[n]);
            exc_clr[n] = exc_ack && (exc_line == n[3:0]) &&
                         ((sense_all[2*n +: 2] != eifkm_pkg::SENSE_LOW) || src_n[n]);
        end
    end

    // Set wins over any clear in the same cycle
    wire [15:0] flag_d    = set_ev | (flag_q & ~(sw_clr | exc_clr));
    wire [15:0] rd_seen_d = (rd_seen_q | rd_one) & flag_d;
    wire [15:0] new_ev    = set_ev & ~flag_q;
    wire [15:0] sts_w1c   = (wr_acc & sel_is) ? whalf : 16'h0000;
    wire [15:0] sts_d     = new_ev | (sts_q & ~sts_w1c);

    // Key mask six gates line six only in compatible mode
    wire [15:0] kgate     = {9'h000, ~evs_q & kmask_lo_q[eifkm_pkg::KMASK_SIX], 6'h00};
    assign request_pending = flag_q & enable_q & ~kgate;
    assign key_sense_hit   = key_hit_q;
    assign wake_event_hit  = wake_hit_q;
    assign irq             = |(sts_q & msk_q);

    // Switching to extended mode forces mask six high
    wire evs_rise = wr_acc & sel_sc & avs_writedata[eifkm_pkg::EVS_BIT] & ~evs_q;

    // Bus handshake and read data capture
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Flags, read record, pin history
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flag_q    <= eifkm_pkg::RST_FLAGS;
            rd_seen_q <= eifkm_pkg::RST_FLAGS;
            prev_n_q  <= eifkm_pkg::RST_PIN_IDLE;
        end else begin
            flag_q    <= flag_d;
            rd_seen_q <= rd_seen_d;
            prev_n_q  <= src_n;
        end
    end

    // Key and wake masks, reset to disabled except key mask bit six
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            kmask_hi_q <= eifkm_pkg::RST_KMASK_HI;
            kmask_lo_q <= eifkm_pkg::RST_KMASK_LO;
            wmask_q    <= eifkm_pkg::RST_WMASK;
        end else begin
            if (wr_acc && sel_kmh) begin
                kmask_hi_q <= wbyte;
            end
            if (wr_acc && sel_kml) begin
                kmask_lo_q <= wbyte;
            end else if (evs_rise) begin
                kmask_lo_q[eifkm_pkg::KMASK_SIX] <= 1'b1;
            end
            if (wr_acc && sel_wm) begin
                wmask_q <= wbyte;
            end
        end
    end

    // Sense, enable, pin select, mode
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sense_hi_q <= eifkm_pkg::RST_SENSE;
            sense_lo_q <= eifkm_pkg::RST_SENSE;
            enable_q   <= eifkm_pkg::RST_ENABLE;
            pin_sel_q  <= eifkm_pkg::RST_PIN_SEL;
            evs_q      <= 1'b0;
        end else begin
            if (wr_acc && sel_sh) begin
                sense_hi_q <= whalf;
            end
            if (wr_acc && sel_sl) begin
                sense_lo_q <= whalf; // software keeps lines 6/7 low or falling
            end
            if (wr_acc && sel_en) begin
                enable_q <= whalf;
            end
            if (wr_acc && sel_ps) begin
                pin_sel_q <= whalf & eifkm_pkg::PIN_SEL_WMSK;
            end
            if (wr_acc && sel_sc) begin
                evs_q <= avs_writedata[eifkm_pkg::EVS_BIT];
            end
        end
    end

    // Event status, mask, and masked key/wake levels
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sts_q      <= 16'h0000;
            msk_q      <= 16'h0000;
            key_hit_q  <= 16'h0000;
            wake_hit_q <= 8'h00;
        end else begin
            sts_q      <= sts_d;
            key_hit_q  <= ~key_sense_input_n & ~{kmask_hi_q, kmask_lo_q};
            wake_hit_q <= ~wake_event_input_n & ~wmask_q;
            if (wr_acc && sel_im) begin
                msk_q <= whalf;
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_flag_fall_cause: assert property (
        1'b1 |=> ((~flag_q & $past(flag_q) & ~$past(sw_clr | exc_clr)) == 16'h0000))
        else $error("flag cleared without a qualified clear");

    a_write_one_noset: assert property (
        (wr_acc && sel_flo && set_ev[7:0] == 8'h00)
        |=> ((flag_q[7:0] & ~$past(flag_q[7:0])) == 8'h00))
        else $error("write set a flag");

    a_zero_needs_read: assert property (
        (wr_acc && sel_flo && rd_seen_q[7:0] == 8'h00 && !exc_ack)
        |=> (($past(flag_q[7:0]) & ~flag_q[7:0]) == 8'h00))
        else $error("zero write cleared an unread flag");

    a_edge_exc_clear: assert property (
        (exc_ack && exc_line == 4'h3 && sense_lo_q[7:6] != eifkm_pkg::SENSE_LOW
         && !set_ev[3]) |=> !flag_q[3])
        else $error("edge flag kept after exception handling");

    a_level_exc_hold: assert property (
        (exc_ack && exc_line == 4'h2 && sense_lo_q[5:4] == eifkm_pkg::SENSE_LOW
         && flag_q[2] && !src_n[2] && !sw_clr[2]) |=> flag_q[2])
        else $error("level flag cleared while pin low");

    a_mask_reset_val: assert property (
        $rose(nrst) |-> (kmask_hi_q == 8'hFF && wmask_q == 8'hFF && kmask_lo_q == 8'hBF))
        else $error("mask reset value wrong");

    a_alt6_extended: assert property (
        (evs_q && sense_lo_q[13:12] == eifkm_pkg::SENSE_FALL
         && $fell(alternate_request_pin_n[6])) |-> ##1 flag_q[6])
        else $error("alternate six did not set flag in extended mode");

    a_pin7_ignored: assert property (
        (!evs_q && !kh_all && key_sense_input_n[15:8] == 8'hFF && !flag_q[7]
         && sense_lo_q[15:14] == eifkm_pkg::SENSE_LOW) |=> !flag_q[7])
        else $error("request seven pin not ignored");

    a_six_gate: assert property (
        (!evs_q && kmask_lo_q[6]) |-> !request_pending[6])
        else $error("line six passed with mask six set");

    a_pend_enable: assert property (
        (request_pending & ~enable_q) == 16'h0000)
        else $error("request pending without enable");

    a_wait_one: assert property (
        (req && !ack_q) |=> (!avs_waitrequest || !req) [*2])
        else $error("waitrequest held too long");

    // Flag set, clear, read record, pending and status checks
    a_flag_rst_zero: assert property (
        $rose(nrst)
        |-> (flag_q == eifkm_pkg::RST_FLAGS))
        else $error("flag not zero after reset");

    a_set_from_event: assert property (
        (set_ev != 16'h0000)
        |=> ((flag_q & $past(set_ev)) == $past(set_ev)))
        else $error("selected condition did not set flag");

    a_level_exc_clear: assert property (
        (exc_ack && exc_line == 4'h2 && sense_lo_q[5:4] == eifkm_pkg::SENSE_LOW && src_n[2])
        |=> !flag_q[2])
        else $error("level flag kept with pin high");

    a_read_record: assert property (
        (rd_acc && sel_flo)
        |=> (($past(rdata_q[7:0]) & flag_q[7:0] & ~rd_seen_q[7:0]) == 8'h00))
        else $error("flag read as one not recorded");

    a_fall_sets: assert property (
        (sense_lo_q[1:0] == eifkm_pkg::SENSE_FALL && prev_n_q[0] && !src_n[0])
        |=> flag_q[0])
        else $error("falling edge did not set flag");

    a_rise_sets: assert property (
        (sense_lo_q[1:0] == eifkm_pkg::SENSE_RISE && !prev_n_q[0] && src_n[0])
        |=> flag_q[0])
        else $error("rising edge did not set flag");

    a_rise_no_fall: assert property (
        (sense_lo_q[1:0] == eifkm_pkg::SENSE_RISE && prev_n_q[0] && !src_n[0] && !flag_q[0])
        |=> !flag_q[0])
        else $error("falling edge set a rising flag");

    a_enable_pend: assert property (
        (flag_q[0] && enable_q[0])
        |-> request_pending[0])
        else $error("enabled flag not pending");

    a_status_w1c: assert property (
        (wr_acc && sel_is)
        |=> ((sts_q & $past(whalf & ~new_ev)) == 16'h0000))
        else $error("status bit not cleared by one");

    // Mask, key and wake checks
    a_kmask_write: assert property (
        (wr_acc && sel_kmh)
        |=> (kmask_hi_q == $past(wbyte)))
        else $error("upper key mask write lost");

    a_key_masked_off: assert property (
        1'b1
        |=> ((key_sense_hit & $past({kmask_hi_q, kmask_lo_q})) == 16'h0000))
        else $error("masked key input reported");

    a_key_low_hit: assert property (
        (!key_sense_input_n[1] && !kmask_lo_q[1])
        |=> key_sense_hit[1])
        else $error("enabled key input not reported");

    a_wake_masked_off: assert property (
        1'b1
        |=> ((wake_event_hit & $past(wmask_q)) == 8'h00))
        else $error("masked wake input reported");

    a_wake_low_hit: assert property (
        (!wake_event_input_n[8] && !wmask_q[0])
        |=> wake_event_hit[8])
        else $error("enabled wake input not reported");

    // Vector mode and line source checks
    a_mode_six_set: assert property (
        evs_rise
        |=> kmask_lo_q[eifkm_pkg::KMASK_SIX])
        else $error("mask six not forced in extended mode");

    a_alt6_blocked: assert property (
        (!evs_q && !flag_q[6] && primary_request_pin_n[6] && key_lo_n && prev_n_q[6])
        |=> !flag_q[6])
        else $error("alternate six reached line six");

    a_alt6_level: assert property (
        (evs_q && sense_lo_q[13:12] == eifkm_pkg::SENSE_LOW && !alternate_request_pin_n[6])
        |=> flag_q[6])
        else $error("alternate six low did not set flag");

    a_pin7_source: assert property (
        (!evs_q && kh_all && !primary_request_pin_n[7]
         && sense_lo_q[15:14] == eifkm_pkg::SENSE_LOW)
        |=> flag_q[7])
        else $error("request seven pin not used");

    c_read_then_clear: cover property (rd_acc && sel_flo ##[1:20] wr_acc && sel_flo);
    c_exc_clear: cover property (|(exc_clr & flag_q & ~set_ev));
    c_extended_six: cover property (evs_q && $rose(flag_q[6]));
    c_irq_raise: cover property ($rose(irq));

endmodule : eifkm_core

// ### tb_ext_irq_flag_and_key_mask.sv
// Self-checking testbench for the external request flag and key mask block
`timescale 1ns/100ps
module tb_ext_irq_flag_and_key_mask;
    // Clock, reset and register bus
    logic        core_clk;
    logic        nrst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    // Pins, acknowledge and outputs
    logic [15:0] prim_n;
    logic [15:6] alt_n;
    logic [15:0] key_n;
    logic [15:8] wake_n;
    logic        exc_ack;
    logic [3:0]  exc_line;
    logic [15:0] request_pending;
    logic [15:0] key_sense_hit;
    logic [15:8] wake_event_hit;
    logic        irq;
    int          error_cnt;
    int          n_checks;

    eifkm_core i_eifkm_core (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .primary_request_pin_n(prim_n), .alternate_request_pin_n(alt_n),
        .key_sense_input_n(key_n), .wake_event_input_n(wake_n),
        .exc_ack(exc_ack), .exc_line(exc_line), .request_pending(request_pending),
        .key_sense_hit(key_sense_hit), .wake_event_hit(wake_event_hit), .irq(irq)
    );

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // One Avalon-MM transfer; waitrequest and read data taken at the rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 16) begin
            error_cnt++;
            give_verdict();
        end else begin
            q = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            // Idle edge so registered effects settle before outputs are judged
            @(posedge core_clk);
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask : rdc

    // Read first so the zero write qualifies as a clear
    task automatic clr_lo(input logic [7:0] bits);
        logic [31:0] q;
        bus(1'b0, eifkm_pkg::OFS_FLAGS_LO, 32'h0, q);
        wr(eifkm_pkg::OFS_FLAGS_LO, {24'h0, ~bits});
    endtask : clr_lo

    // Pin change, then time for sampling and flag update
    task automatic pin(input int n, input logic v);
        @(posedge core_clk);
        prim_n[n] <= v;
        repeat (3) @(posedge core_clk);
    endtask : pin

    task automatic ack(input logic [3:0] n);
        @(posedge core_clk);
        exc_ack  <= 1'b1;
        exc_line <= n;
        @(posedge core_clk);
        exc_ack  <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : ack

    task automatic t_reset();
        rdc(eifkm_pkg::OFS_FLAGS_HI, 32'h0, "flags high");
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h0, "flags low");
        rdc(eifkm_pkg::OFS_KMASK_HI, 32'hFF, "key mask high");
        rdc(eifkm_pkg::OFS_KMASK_LO, 32'hBF, "key mask low");
        rdc(eifkm_pkg::OFS_WMASK, 32'hFF, "wake mask");
        rdc(8'h30, 32'h0, "unmapped");
    endtask : t_reset

    // Every sense code on line 0, fall then rise, enable on odd codes only
    task automatic t_sense();
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr(eifkm_pkg::OFS_SENSE_LO, {30'h0, m});
            wr(eifkm_pkg::OFS_ENABLE, {31'h0, m[0]});
            pin(0, 1'b0);
            rdc(eifkm_pkg::OFS_FLAGS_LO, {31'h0, m != 2'h2}, "after fall");
            chk({31'h0, request_pending[0]}, {31'h0, m[0] & (m != 2'h2)}, "pend");
            clr_lo(8'h01);
            pin(0, 1'b1);
            rdc(eifkm_pkg::OFS_FLAGS_LO, {31'h0, m != 2'h1}, "after rise");
            clr_lo(8'h01);
        end
        wr(eifkm_pkg::OFS_SENSE_LO, 32'h0);
    endtask : t_sense

    // Zero write needs a prior read of one; ones never set
    task automatic t_clear();
        pin(1, 1'b0);
        pin(1, 1'b1);
        wr(eifkm_pkg::OFS_FLAGS_LO, 32'h0);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h02, "zero write unread");
        wr(eifkm_pkg::OFS_FLAGS_LO, 32'hFF);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h02, "one write");
        wr(eifkm_pkg::OFS_FLAGS_LO, 32'h0);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h0, "zero write after read");
        pin(1, 1'b0);
        pin(1, 1'b1);
        wr(eifkm_pkg::OFS_FLAGS_LO, 32'h0);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h02, "stale read record");
        clr_lo(8'h02);
    endtask : t_clear

    // Line 2 low level, line 3 falling edge
    task automatic t_exc();
        wr(eifkm_pkg::OFS_SENSE_LO, 32'h40);
        pin(2, 1'b0);
        pin(3, 1'b0);
        ack(4'h2);
        ack(4'h3);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h04, "ack pin low");
        pin(2, 1'b1);
        ack(4'h2);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h0, "ack pin high");
        pin(3, 1'b1);
        wr(eifkm_pkg::OFS_SENSE_LO, 32'h0); // line 3 back to low level
    endtask : t_exc

    task automatic t_keys();
        wr(eifkm_pkg::OFS_KMASK_HI, 32'h5A);
        wr(eifkm_pkg::OFS_KMASK_LO, 32'hA5);
        wr(eifkm_pkg::OFS_WMASK, 32'h3C);
        @(posedge core_clk);
        key_n  <= 16'h0000;
        wake_n <= 8'h00;
        repeat (3) @(posedge core_clk);
        chk({16'h0, key_sense_hit}, 32'hA55A, "key hits");
        chk({24'h0, wake_event_hit}, 32'hC3, "wake hits");
        key_n  <= 16'hFFFF;
        wake_n <= 8'hFF;
        repeat (3) @(posedge core_clk);
        chk({16'h0, key_sense_hit}, 32'h0, "keys idle");
        wr(eifkm_pkg::OFS_KMASK_HI, 32'hFF);
        wr(eifkm_pkg::OFS_KMASK_LO, 32'hBF);
        clr_lo(8'hC0);
    endtask : t_keys

    task automatic t_mode();
        wr(eifkm_pkg::OFS_ENABLE, 32'h40);
        wr(eifkm_pkg::OFS_KMASK_HI, 32'hFE);
        pin(7, 1'b0);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h0, "line 7 ignored");
        wr(eifkm_pkg::OFS_KMASK_HI, 32'hFF);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h80, "line 7 from pin");
        pin(7, 1'b1);
        clr_lo(8'h80);
        alt_n[6] <= 1'b0;
        repeat (3) @(posedge core_clk);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h0, "alt six compatible");
        alt_n[6] <= 1'b1;
        pin(6, 1'b0);
        chk({31'h0, request_pending[6]}, 32'h1, "six unmasked");
        wr(eifkm_pkg::OFS_KMASK_LO, 32'hFF);
        chk({31'h0, request_pending[6]}, 32'h0, "six masked");
        pin(6, 1'b1);
        clr_lo(8'h40);
        wr(eifkm_pkg::OFS_KMASK_LO, 32'hBF);
        wr(eifkm_pkg::OFS_SYSCTL, 32'h1);
        rdc(eifkm_pkg::OFS_KMASK_LO, 32'hFF, "bit six extended");
        alt_n[6] <= 1'b0;
        repeat (3) @(posedge core_clk);
        rdc(eifkm_pkg::OFS_FLAGS_LO, 32'h40, "alt six extended");
        chk({31'h0, request_pending[6]}, 32'h1, "bit six no gate");
        alt_n[6] <= 1'b1;
        clr_lo(8'h40);
    endtask : t_mode

    task automatic t_irq();
        wr(eifkm_pkg::OFS_IRQ_STS, 32'hFFFF);
        rdc(eifkm_pkg::OFS_IRQ_STS, 32'h0, "status cleared");
        pin(4, 1'b0);
        pin(4, 1'b1);
        rdc(eifkm_pkg::OFS_IRQ_STS, 32'h10, "status set");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(eifkm_pkg::OFS_IRQ_MSK, 32'h10);
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(eifkm_pkg::OFS_IRQ_STS, 32'h10);
        chk({31'h0, irq}, 32'h0, "irq cleared");
    endtask : t_irq

    // Main sequence
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        prim_n = 16'hFFFF;
        alt_n = 10'h3FF;
        key_n = 16'hFFFF;
        wake_n = 8'hFF;
        exc_ack = 1'b0;
        exc_line = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_sense();
        t_clear();
        t_exc();
        t_keys();
        t_mode();
        t_irq();
        give_verdict();
    end
endmodule : tb_ext_irq_flag_and_key_mask
